//--- design/scsit_pkg.sv
// Contract
// - Only the target drives the phase lines.
// - Six phases encoded as C/D, I/O, MSG.
// - Never drive the two reserved phase codes.
// - Bus free: release MSG, C/D, I/O, BSY.
// - One byte per complete REQ/ACK handshake.
// - BSY asserted, SEL negated during transfer phases.
// - Phase lines settle before REQ, held past ACK.
// - I/O asserted sends bytes to the initiator.
// - Outbound: data, deskew plus skew, REQ, hold.
// - Outbound: ACK seen, drop REQ; initiator drops ACK.
// - Outbound: next byte only after ACK negated.
// - Inbound: target opens each byte with REQ.
// - Inbound: sample on ACK, then negate REQ.
// - Nonzero logical unit gives illegal request.
// - Relative addressing set gives illegal request.
// - Nonzero control byte gives illegal request.
// - Nonzero reserved bits give illegal request.
// - Decode opcodes 16, 17 and 12.
// - Decode opcodes 03, 00 and 24.
// - Decode opcodes 28 and 31.
// - Wait for SEL negated before first REQ.
// Package of constants, types and register layout for the SCSI target phase engine.
// Assumes a 125 MHz core clock and selection handled by outside logic.
package scsit_pkg;

  // Clock and bus delays, in ns, and their cycle counts rounded up
  localparam int CLK_PERIOD_NS  = 8;
  localparam int SETTLE_NS      = 400;
  localparam int DESKEW_NS      = 45;
  localparam int CABLE_SKEW_NS  = 10;
  localparam int SETTLE_CYC_I   = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SKEW_CYC_I     = (DESKEW_NS + CABLE_SKEW_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_CYC = 8'(SETTLE_CYC_I < 1 ? 1 : SETTLE_CYC_I);
  localparam logic [7:0] SKEW_CYC   = 8'(SKEW_CYC_I < 1 ? 1 : SKEW_CYC_I);

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_COUNT  = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CDBRES = 8'h14;

  // Control and status bit positions
  localparam int CTRL_START   = 0;
  localparam int CTRL_PH_LO   = 1;
  localparam int CTRL_PH_HI   = 3;
  localparam int CTRL_RELEASE = 4;
  localparam int CTRL_BUSY    = 5;
  localparam int ST_DONE      = 0;
  localparam int ST_PERR      = 1;
  localparam int ST_RXAV      = 2;
  localparam int ST_TXFULL    = 3;
  localparam int ST_ATN       = 4;
  localparam int ST_SEL       = 5;
  localparam int ST_BUSY      = 6;
  localparam int ST_ACTIVE    = 7;
  localparam int ST_SCREENED  = 8;

  // Operation codes
  localparam logic [7:0] OP_TEST_READY = 8'h00;
  localparam logic [7:0] OP_REQ_SENSE  = 8'h03;
  localparam logic [7:0] OP_INQUIRY    = 8'h12;
  localparam logic [7:0] OP_RESERVE    = 8'h16;
  localparam logic [7:0] OP_RELEASE    = 8'h17;
  localparam logic [7:0] OP_SCAN       = 8'h1B;
  localparam logic [7:0] OP_DIAG       = 8'h1D;
  localparam logic [7:0] OP_SET_WINDOW = 8'h24;
  localparam logic [7:0] OP_READ       = 8'h28;
  localparam logic [7:0] OP_OBJ_POS    = 8'h31;

  // Status and sense values, command block geometry
  localparam logic [4:0] STATUS_CHECK   = 5'h01;
  localparam logic [3:0] SENSE_NONE     = 4'h0;
  localparam logic [3:0] SENSE_ILLEGAL  = 4'h5;
  localparam logic [3:0] CDB_SHORT      = 4'h6;
  localparam logic [3:0] CDB_LONG       = 4'hA;
  localparam int         CDB_MAX        = 10;

  // Phases in their index order on the control register
  typedef enum logic [2:0] {
    PH_DATA_OUT, PH_DATA_IN, PH_COMMAND, PH_STATUS, PH_MSG_OUT, PH_MSG_IN
  } scsit_phase_e;

  // Decoded command
  typedef enum logic [3:0] {
    CMD_NONE, CMD_TEST_READY, CMD_REQ_SENSE, CMD_INQUIRY, CMD_RESERVE, CMD_RELEASE,
    CMD_SCAN, CMD_DIAG, CMD_SET_WINDOW, CMD_READ, CMD_OBJ_POS, CMD_UNKNOWN
  } scsit_cmd_e;

  // Target-driven bus lines; phase lines are driven low when released
  typedef struct packed {
    logic       bsy_oe;
    logic       cd;
    logic       io;
    logic       msg;
    logic       req;
    logic [7:0] db_out;
    logic       dbp_out;
    logic       db_oe;
  } scsit_pins_s;

  // Result of command block screening
  typedef struct packed {
    logic       valid;
    logic       check;
    logic [3:0] sense;
    scsit_cmd_e cmd;
    logic [7:0] opcode;
  } scsit_screen_s;

endpackage

//--- design/scsit_target.sv
// Target end of the parallel SCSI information transfer phases with command screening.
// Assumes outside logic wins selection and then sets the busy bit over the register port.
`timescale 1ns/10ps
module scsit_target
  import scsit_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        sel_in,
  input  wire logic        atn_in,
  input  wire logic        ack_in,
  input  wire logic [7:0]  db_in,
  input  wire logic        dbp_in,
  output scsit_pins_s      pins
);

  typedef enum logic [3:0] {
    S_IDLE, S_WAIT_SEL, S_SETTLE, S_BYTE, S_OUT_SKEW, S_OUT_REQ, S_IN_REQ, S_WAIT_NACK
  } scsit_state_e;

  // Odd parity over a data byte
  function automatic logic odd_par(input logic [7:0] d);
    return ~(^d);
  endfunction

  // C/D, I/O, MSG for a phase; only the six defined codes can come out
  function automatic logic [2:0] phase_lines(input scsit_phase_e p);
    case (p)
      PH_DATA_OUT: phase_lines = 3'h0;
      PH_DATA_IN:  phase_lines = 3'h2;
      PH_COMMAND:  phase_lines = 3'h4;
      PH_STATUS:   phase_lines = 3'h6;
      PH_MSG_OUT:  phase_lines = 3'h5;
      PH_MSG_IN:   phase_lines = 3'h7;
      default:     phase_lines = 3'h0;
    endcase
  endfunction

  // Three-stage synchronisers for the pins; a level counts once stages two and three agree
  // Every bus line reaches the core through this filter, so a level change at a pin
  // is seen three to four clocks later. Data and parity pass the same path as ACK,
  // which keeps them aligned: the initiator holds data from before ACK rises until
  // after REQ falls, so the filtered byte is settled by the time ACK is seen.
  // Only the second stage reads the first; stages two and three feed the filter,
  // and only the filter feeds the engine. The filter holds its old value while stages two and three disagree,
  // so a single glitch shorter than a clock never reaches the state machine.
  // The cost is latency: each handshake edge spends roughly four clocks here.
  localparam int SW = 12;
  logic [SW-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;

  always_comb begin
    for (int i = 0; i < SW; i++) begin
      filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg   <= {sel_in, atn_in, ack_in, dbp_in, db_in};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  logic       sel_f, atn_f, ack_f, dbp_f;
  logic [7:0] db_f;
  assign {sel_f, atn_f, ack_f, dbp_f, db_f} = filt_reg;

  // Transfer state and software visible state
  // The byte counter, holding byte and receive byte are shared with software;
  // the engine changes them only in its own states, software only by strobes.
  // A length of zero ends a phase once the settle time has passed, with done set and no handshake.
  // The command block store is a small array that lives here, filled only while
  // the phase is COMMAND; bytes beyond the tenth are counted but not kept.
  scsit_state_e  st_reg, st_next;
  scsit_phase_e  ph_reg, ph_next;
  logic [7:0]    cnt_reg, cnt_next;
  logic [15:0]   left_reg, left_next;
  logic [15:0]   len_reg, len_next;
  logic          busy_reg, busy_next;
  logic [7:0]    tx_reg, tx_next;
  logic          txf_reg, txf_next;
  logic [7:0]    rx_reg, rx_next;
  logic          rxav_reg, rxav_next;
  logic          done_reg, done_next;
  logic          perr_reg, perr_next;
  logic [7:0]    cdb_reg [CDB_MAX];
  logic [7:0]    cdb_next [CDB_MAX];
  logic [3:0]    idx_reg, idx_next;
  scsit_screen_s scr_reg, scr_next;
  scsit_pins_s   pins_next;
  logic [31:0]   rdata_next;

  // Decoded register strobes
  logic wr_ctrl, wr_count, wr_tx, wr_stat, rd_rx;
  assign wr_ctrl  = reg_wr && (reg_addr == ADDR_CTRL);
  assign wr_count = reg_wr && (reg_addr == ADDR_COUNT);
  assign wr_tx    = reg_wr && (reg_addr == ADDR_TXDATA);
  assign wr_stat  = reg_wr && (reg_addr == ADDR_STATUS);
  assign rd_rx    = reg_rd && (reg_addr == ADDR_RXDATA);

  // Screen a collected command block
  // Byte 0 holds the operation code, byte 1 the unit number in its top three
  // bits, the relative address flag in bit 0 and reserved bits between them.
  // The control byte is the last byte of the block, whose length follows the
  // group code in the top bits of the operation code. Any failing test gives
  // check condition with illegal request; the tests are independent, so one
  // block may fail several at once and still reports one sense key.
  // Unknown operation codes are screened the same way, so software never has
  // to decode an opcode itself before answering the host.
  function automatic scsit_screen_s screen(input logic [7:0] c0, input logic [7:0] c1,
                                           input logic [7:0] ctl);
    scsit_screen_s r;
    logic          bad;
    r.valid  = 1'b1;
    r.opcode = c0;
    case (c0)
      OP_RESERVE:    r.cmd = CMD_RESERVE;
      OP_RELEASE:    r.cmd = CMD_RELEASE;
      OP_INQUIRY:    r.cmd = CMD_INQUIRY;
      OP_REQ_SENSE:  r.cmd = CMD_REQ_SENSE;
      OP_TEST_READY: r.cmd = CMD_TEST_READY;
      OP_SET_WINDOW: r.cmd = CMD_SET_WINDOW;
      OP_READ:       r.cmd = CMD_READ;
      OP_OBJ_POS:    r.cmd = CMD_OBJ_POS;
      OP_DIAG:       r.cmd = CMD_DIAG;
      OP_SCAN:       r.cmd = CMD_SCAN;
      default:       r.cmd = CMD_UNKNOWN;
    endcase
    bad = (c1[7:5] != 3'h0)
        || c1[0]
        || (ctl != 8'h00)
        || (c1[4:1] != 4'h0)
        || (r.cmd == CMD_UNKNOWN);
    r.check = bad;
    r.sense = bad ? SENSE_ILLEGAL : SENSE_NONE;
    return r;
  endfunction

  // Next state of the handshake engine and the registers it shares with software
  // Software starts one phase at a time: it writes the count, for outbound data
  // fills the holding byte, then writes start with a phase index. The engine
  // waits for SEL to fall, drives the phase lines, lets them settle, and then
  // runs one REQ/ACK handshake per byte. REQ only rises from a state in which
  // ACK has been seen low, so a slow initiator can never skip a handshake.
  // Phase lines and BSY stay driven after the last byte so that software can
  // chain phases without a glitch on the bus; release drops everything at once.
  // Status flags set by the engine win over a clear written in the same cycle,
  // so an event is never lost to a late clear.
  // Trade-off: no prefetch buffer, so the outbound rate is bounded by how fast
  // software refills the holding byte after each ACK.
  always_comb begin
    logic [3:0] clen;
    clen       = (cdb_reg[0][7:5] == 3'h0) ? CDB_SHORT : CDB_LONG;
    st_next    = st_reg;
    ph_next    = ph_reg;
    cnt_next   = cnt_reg;
    left_next  = left_reg;
    len_next   = wr_count ? reg_wdata[15:0] : len_reg;
    busy_next  = busy_reg;
    tx_next    = tx_reg;
    txf_next   = txf_reg;
    rx_next    = rx_reg;
    rxav_next  = rxav_reg && !rd_rx;
    done_next  = done_reg && !(wr_stat && reg_wdata[ST_DONE]);
    perr_next  = perr_reg && !(wr_stat && reg_wdata[ST_PERR]);
    cdb_next   = cdb_reg;
    idx_next   = idx_reg;
    scr_next   = scr_reg;
    pins_next  = pins;
    // Holding byte accepted only while empty; a write when full is dropped
    if (wr_tx && !txf_reg) begin
      tx_next  = reg_wdata[7:0];
      txf_next = 1'b1;
    end
    case (st_reg)
      S_IDLE: begin
        if (wr_ctrl && reg_wdata[CTRL_RELEASE]) begin
          busy_next      = 1'b0;
          pins_next      = '0;
        end else if (wr_ctrl && reg_wdata[CTRL_BUSY]) begin
          busy_next      = 1'b1;
          pins_next.bsy_oe = 1'b1;
        end
        // Reserved phase indexes and starts without BSY are ignored
        if (wr_ctrl && reg_wdata[CTRL_START] && (busy_reg || reg_wdata[CTRL_BUSY])
            && !reg_wdata[CTRL_RELEASE] && (reg_wdata[CTRL_PH_HI:CTRL_PH_LO] < 3'h6)) begin
          ph_next   = scsit_phase_e'(reg_wdata[CTRL_PH_HI:CTRL_PH_LO]);
          left_next = len_next;
          idx_next  = 4'h0;
          if (scsit_phase_e'(reg_wdata[CTRL_PH_HI:CTRL_PH_LO]) == PH_COMMAND) begin
            scr_next.valid = 1'b0;
          end
          st_next   = S_WAIT_SEL;
        end
      end
      S_WAIT_SEL: begin
        // Selector still holds SEL: no phase may begin under it
        if (!sel_f) begin
          {pins_next.cd, pins_next.io, pins_next.msg} = phase_lines(ph_reg);
          pins_next.bsy_oe = 1'b1;
          cnt_next = SETTLE_CYC;
          st_next  = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (cnt_reg > 8'h01) begin
          cnt_next = cnt_reg - 8'h01;
        end else begin
          st_next = S_BYTE;
        end
      end
      S_BYTE: begin
        if (left_reg == 16'h0000) begin
          // Phase lines stay as they are until software starts another phase
          done_next = 1'b1;
          st_next   = S_IDLE;
        end else if (pins.io) begin
          if (txf_reg) begin
            pins_next.db_out  = tx_reg;
            pins_next.dbp_out = odd_par(tx_reg);
            pins_next.db_oe   = 1'b1;
            cnt_next = SKEW_CYC;
            st_next  = S_OUT_SKEW;
          end
        end else if (!rxav_reg) begin
          // Stall REQ until software has taken the previous byte
          pins_next.db_oe = 1'b0;
          pins_next.req   = 1'b1;
          st_next = S_IN_REQ;
        end
      end
      S_OUT_SKEW: begin
        if (cnt_reg > 8'h01) begin
          cnt_next = cnt_reg - 8'h01;
        end else begin
          pins_next.req = 1'b1;
          st_next = S_OUT_REQ;
        end
      end
      S_OUT_REQ: begin
        if (ack_f) begin
          pins_next.req   = 1'b0;
          pins_next.db_oe = 1'b0;
          txf_next  = 1'b0;
          left_next = left_reg - 16'h0001;
          st_next   = S_WAIT_NACK;
        end
      end
      S_IN_REQ: begin
        if (ack_f) begin
          rx_next   = db_f;
          rxav_next = 1'b1;
          if (dbp_f != odd_par(db_f)) begin
            perr_next = 1'b1;
          end
          if (ph_reg == PH_COMMAND && idx_reg < 4'(CDB_MAX)) begin
            cdb_next[idx_reg] = db_f;
            idx_next = idx_reg + 4'h1;
          end
          pins_next.req = 1'b0;
          left_next = left_reg - 16'h0001;
          st_next   = S_WAIT_NACK;
        end
      end
      S_WAIT_NACK: begin
        // Next byte and phase change both wait for ACK to fall
        if (!ack_f) begin
          if (left_reg == 16'h0000 && ph_reg == PH_COMMAND) begin
            scr_next = screen(cdb_reg[0], cdb_reg[1], cdb_reg[clen - 4'h1]);
          end
          st_next = S_BYTE;
        end
      end
      default: begin
        st_next   = S_IDLE;
        pins_next = '0;
      end
    endcase
  end

  // Read mux; data stands only in the cycle after the strobe
  // Idle cycles read as zero so a stray sample outside the read slot is harmless.
  // Reading RXDATA also clears the receive flag, which releases a stalled REQ.
  // Unmapped addresses read zero and cost nothing.
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL:   rdata_next = {26'h0, busy_reg, 1'b0, ph_reg, 1'b0};
        ADDR_COUNT:  rdata_next = {len_reg, left_reg};
        ADDR_TXDATA: rdata_next = {24'h0, tx_reg};
        ADDR_RXDATA: rdata_next = {24'h0, rx_reg};
        ADDR_STATUS: begin
          rdata_next[ST_DONE]     = done_reg;
          rdata_next[ST_PERR]     = perr_reg;
          rdata_next[ST_RXAV]     = rxav_reg;
          rdata_next[ST_TXFULL]   = txf_reg;
          rdata_next[ST_ATN]      = atn_f;
          rdata_next[ST_SEL]      = sel_f;
          rdata_next[ST_BUSY]     = busy_reg;
          rdata_next[ST_ACTIVE]   = (st_reg != S_IDLE);
          rdata_next[ST_SCREENED] = scr_reg.valid;
        end
        ADDR_CDBRES: rdata_next = {9'h0, scr_reg.valid, scr_reg.check,
                                   scr_reg.check ? STATUS_CHECK : 5'h00,
                                   scr_reg.sense, scr_reg.cmd, scr_reg.opcode};
        default:     rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // All state registers
  // Reset puts every bus line low, which is bus free with nothing driven.
  // The outputs are taken straight from these flip-flops so that no decode
  // glitch can reach the bus lines or the read data.
  // Reset assigns only constants; the command store is cleared word by word.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_reg    <= S_IDLE;
      ph_reg    <= PH_DATA_OUT;
      cnt_reg   <= 8'h00;
      left_reg  <= 16'h0000;
      len_reg   <= 16'h0000;
      busy_reg  <= 1'b0;
      tx_reg    <= 8'h00;
      txf_reg   <= 1'b0;
      rx_reg    <= 8'h00;
      rxav_reg  <= 1'b0;
      done_reg  <= 1'b0;
      perr_reg  <= 1'b0;
      idx_reg   <= 4'h0;
      scr_reg   <= '0;
      pins      <= '0;
      reg_rdata <= 32'h0000_0000;
      for (int i = 0; i < CDB_MAX; i++) begin
        cdb_reg[i] <= 8'h00;
      end
    end else begin
      st_reg    <= st_next;
      ph_reg    <= ph_next;
      cnt_reg   <= cnt_next;
      left_reg  <= left_next;
      len_reg   <= len_next;
      busy_reg  <= busy_next;
      tx_reg    <= tx_next;
      txf_reg   <= txf_next;
      rx_reg    <= rx_next;
      rxav_reg  <= rxav_next;
      done_reg  <= done_next;
      perr_reg  <= perr_next;
      idx_reg   <= idx_next;
      scr_reg   <= scr_next;
      pins      <= pins_next;
      reg_rdata <= rdata_next;
      cdb_reg   <= cdb_next;
    end
  end

endmodule

//--- dv/scsit_sva.sv
// Checker for the target phase engine: bus-side handshake and phase timing.
// Assumes it is bound to scsit_target and sees only that module's ports.
`timescale 1ns/10ps
module scsit_sva
  import scsit_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        sel_in,
  input wire logic        ack_in,
  input wire scsit_pins_s pins
);
  logic [3:0] ph_last;
  logic [9:0] db_last;
  logic [7:0] ph_age;
  logic [7:0] oe_age;

  // Ages of phase lines and of the driven byte; saturate so long phases never wrap
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ph_last <= '0;
      db_last <= '0;
      ph_age  <= '0;
      oe_age  <= '0;
    end else begin
      ph_last <= {pins.bsy_oe, pins.cd, pins.io, pins.msg};
      db_last <= {pins.db_oe, pins.dbp_out, pins.db_out};
      if (ph_last != {pins.bsy_oe, pins.cd, pins.io, pins.msg}) ph_age <= 8'h00;
      else if (ph_age != 8'hFF) ph_age <= ph_age + 8'h01;
      if (!pins.db_oe || db_last != {pins.db_oe, pins.dbp_out, pins.db_out}) oe_age <= 8'h00;
      else if (oe_age != 8'hFF) oe_age <= oe_age + 8'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Steps of one handshake
  sequence req_up;
    $rose(pins.req);
  endsequence
  sequence ack_up_req;
    $rose(ack_in) ##0 pins.req;
  endsequence

  phase_code_legal_a: assert property (pins.bsy_oe |-> !(!pins.cd && pins.msg))
    else $error("reserved phase code driven");
  settle_before_req_a: assert property (req_up |-> ph_age >= SETTLE_CYC - 8'h01)
    else $error("REQ before phase lines settled");
  skew_before_req_a: assert property (req_up ##0 pins.io |-> oe_age >= SKEW_CYC - 8'h01)
    else $error("REQ before data skew time");
  data_hold_a: assert property (pins.req && pins.io |-> pins.db_oe && $stable(pins.db_out))
    else $error("outbound data not held under REQ");
  busy_no_sel_a: assert property (pins.req |-> pins.bsy_oe && !sel_in)
    else $error("REQ without BSY or with SEL");
  sel_before_req_a: assert property (req_up |-> !$past(sel_in, 3))
    else $error("REQ while SEL still seen");
  req_drop_a: assert property (ack_up_req |-> ##[1:6] !pins.req)
    else $error("REQ not dropped after ACK");
  req_hold_a: assert property ($fell(pins.req) |-> $past(ack_in, 2))
    else $error("REQ dropped without ACK");
  no_early_req_a: assert property (req_up |-> !$past(ack_in, 1) && !$past(ack_in, 2))
    else $error("REQ raised while ACK high");
  phase_stays_a: assert property ($changed({pins.cd, pins.io, pins.msg}) |->
    !$past(pins.req) && !$past(ack_in))
    else $error("phase lines moved inside handshake");
  parity_odd_a: assert property (pins.db_oe |-> ^{pins.db_out, pins.dbp_out})
    else $error("outbound parity not odd");
  bus_free_a: assert property (!pins.bsy_oe |->
    !(pins.cd || pins.io || pins.msg || pins.req || pins.db_oe))
    else $error("line driven without BSY");
endmodule

//--- dv/scsit_initiator.sv
// Behavioural host initiator answering each REQ with one ACK.
// Assumes the testbench presents the next outbound host byte on tx_byte.
`timescale 1ns/10ps
module scsit_initiator
  import scsit_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire scsit_pins_s pins,
  input  wire logic        slow,
  input  wire logic [7:0]  tx_byte,
  output logic             ack_in,
  output logic [7:0]       db_in,
  output logic             dbp_in,
  output logic             rx_valid,
  output logic [7:0]       rx_byte
);
  // One byte per handshake; slow mode stretches the wait to test target stalls
  initial begin
    ack_in = 1'b0;
    db_in = 8'hA5;
    dbp_in = 1'b1;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    forever begin
      @(posedge ref_clk);
      if (pins.req && !ack_in) begin
        if (pins.io) begin
          rx_byte <= pins.db_out;
          rx_valid <= 1'b1;
        end else begin
          db_in <= tx_byte;
          dbp_in <= ~^tx_byte;
        end
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        repeat (slow ? 25 : 7) @(posedge ref_clk);
        ack_in <= 1'b1;
        while (pins.req) @(posedge ref_clk);
        ack_in <= 1'b0;
        db_in <= ~db_in; // Released lines show junk, not the last byte
        dbp_in <= ~dbp_in;
      end
    end
  end
endmodule

//--- dv/tb.sv
// Self-checking bench: all six phases, then command block screening.
// Assumes scsit_target with its register port and the initiator model beside it.
`timescale 1ns/10ps
module tb;
  import scsit_pkg::*;
  localparam logic [2:0] ENC [6] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h5, 3'h7};
  localparam logic [7:0] OPS [10] = '{8'h00, 8'h03, 8'h12, 8'h16, 8'h17,
                                      8'h1B, 8'h1D, 8'h24, 8'h28, 8'h31};
  logic        ref_clk, reset, reg_wr, reg_rd, sel_in, atn_in, ack_in, dbp_in;
  logic        slow, rx_valid, rd_pend, bad;
  logic [7:0]  reg_addr, db_in, tx_byte, rx_byte, op;
  logic [31:0] reg_wdata, reg_rdata, last, e, m;
  logic [7:0]  cdb [10];
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];
  logic [7:0]  byte_q [$];
  scsit_pins_s pins;
  int          fail_count, total_checks, cyc, seed, i, k, len;

  scsit_target uut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sel_in(sel_in), .atn_in(atn_in), .ack_in(ack_in), .db_in(db_in), .dbp_in(dbp_in),
    .pins(pins));
  scsit_initiator host (.ref_clk(ref_clk), .pins(pins), .slow(slow), .tx_byte(tx_byte),
    .ack_in(ack_in), .db_in(db_in), .dbp_in(dbp_in), .rx_valid(rx_valid), .rx_byte(rx_byte));

  // Free-running clock, 8 ns period
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // A gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] mk);
    exp_q.push_back(x);
    msk_q.push_back(mk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 last = reg_rdata;
    @(posedge ref_clk);
  endtask

  task automatic wait_req(input logic v);
    int n;
    for (n = 0; n < 3000 && pins.req !== v; n++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  // One whole phase of n bytes taken from cdb
  task automatic run_phase(input int ph, input int n);
    int b;
    wr(ADDR_COUNT, 32'(n));
    if (ENC[ph][1]) begin
      wr(ADDR_TXDATA, {24'h0, cdb[0]});
      byte_q.push_back(cdb[0]);
    end
    wr(ADDR_CTRL, 32'h21 | 32'(ph << 1));
    for (b = 0; b < n; b++) begin
      tx_byte <= cdb[b];
      wait_req(1'b1);
      if (b == 0) chk(32'({pins.bsy_oe, pins.cd, pins.io, pins.msg}), {28'h0, 1'b1, ENC[ph]});
      wait_req(1'b0);
      if (!ENC[ph][1]) rd(ADDR_RXDATA, {24'h0, cdb[b]}, 32'hFF);
      else if (b + 1 < n) begin
        wr(ADDR_TXDATA, {24'h0, cdb[b + 1]});
        byte_q.push_back(cdb[b + 1]);
      end
    end
    do rd(ADDR_STATUS, 32'h0, 32'h0); while (last[ST_DONE] !== 1'b1);
    wr(ADDR_STATUS, 32'h1);
  endtask

  // Result watcher and run limit
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      stop_test;
    end
    if (rd_pend && msk_q.size() > 0) begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      if (m != 32'h0) chk(reg_rdata & m, e & m);
    end
    if (rx_valid) chk({24'h0, rx_byte}, byte_q.size() ? {24'h0, byte_q.pop_front()} : 32'hX);
    rd_pend <= reg_rd;
  end

  // Main sequence
  initial begin
    seed = 72027;
    {reset, reg_wr, reg_rd, sel_in, atn_in, slow, rd_pend} = 7'h49;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    tx_byte = 8'h00;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    // SEL needs four clocks through the pin filter before status shows it
    repeat (4) @(posedge ref_clk);
    rd(ADDR_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(ADDR_STATUS, 32'h20, 32'hFFFFFFFF);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    wr(ADDR_CTRL, 32'h20);
    // SEL drops late so the first phase must hold off REQ
    fork
      begin repeat (150) @(posedge ref_clk); sel_in <= 1'b0; end
    join_none
    for (i = 0; i < 6; i++) begin
      for (k = 0; k < 10; k++) cdb[k] = 8'($random(seed));
      slow <= i[0];
      atn_in <= (i == 4);
      run_phase(i, 2);
      if (i == 4) rd(ADDR_STATUS, 32'h10, 32'h11);
    end
    atn_in <= 1'b0;
    for (i = 0; i < 15; i++) begin
      op = i < 10 ? OPS[i] : (i == 14 ? 8'h05 : 8'h12);
      len = op[7:5] == 3'h0 ? 6 : 10;
      for (k = 0; k < 10; k++) cdb[k] = 8'($random(seed));
      cdb[0] = op;
      cdb[1] = i == 10 ? 8'h20 : (i == 11 ? 8'h01 : (i == 13 ? 8'h02 : 8'h00));
      cdb[len - 1] = i == 12 ? 8'h01 : 8'h00;
      bad = i >= 10;
      run_phase(2, len);
      rd(ADDR_CDBRES, {9'h0, 1'b1, bad, bad ? 5'h01 : 5'h00, bad ? 4'h5 : 4'h0,
         4'(i < 10 ? i + 1 : 11), op}, (i < 10 || i == 14) ? 32'h7FFFFF : 32'h7FF0FF);
    end
    wr(ADDR_CTRL, 32'h10);
    @(posedge ref_clk);
    #1 chk(32'(pins), 32'h0);
    rd(ADDR_CTRL, 32'h0, 32'h20);
    repeat (3) @(posedge ref_clk);
    stop_test;
  end
endmodule

bind scsit_target scsit_sva u_sva (.ref_clk(ref_clk), .reset(reset), .sel_in(sel_in),
  .ack_in(ack_in), .pins(pins));
